// ### core/rit_pkg.sv
package rit_pkg;

   // geometry of the RAM group being loaded
   localparam int DATA_W     = 4;
   localparam int ADDR_W     = 2;
   localparam int NUM_BLK    = 4;
   localparam int BLK_W      = 2;
   localparam int IR_W       = 8;
   localparam int FIFO_DEPTH = 32;

   // instruction value that opens the load window
   localparam logic [IR_W-1:0]    START_OPCODE = 8'h22;

   // reset values and sweep limits
   localparam logic [ADDR_W-1:0]  ADDR_INIT   = 2'h3;
   localparam logic [ADDR_W-1:0]  ADDR_LAST   = 2'h3;
   localparam logic [NUM_BLK-1:0] RING_INIT   = 4'h1;
   localparam logic [DATA_W-1:0]  DATA_INIT   = 4'h0;

   // one loaded word as reported to the system side
   typedef struct packed {
      logic [BLK_W-1:0]  blk;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } rit_word_t;

   localparam int WORD_W = $bits(rit_word_t);

   // state on the tap clock
   typedef struct packed {
      logic [DATA_W-1:0]  shift;
      logic [DATA_W-1:0]  wdata;
      logic [ADDR_W-1:0]  addr;
      logic [NUM_BLK-1:0] ring;
      logic               started;
      logic               upd_prev;
      rit_word_t          xfer;
      logic               req;
      logic               ack_s1;
      logic               ack_s2;
      logic               bc_s1;
      logic               bc_s2;
      logic               overrun;
   } rit_tap_st_t;

   // state on the system clock
   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic ack;
      logic ovr_s1;
      logic ovr_s2;
   } rit_sys_st_t;

endpackage

// ### core/rit_loader.sv
// How it works
// - RAMs take contents from logic or tap
// - serial tap bits become parallel RAM word
// - shift register as wide as RAM word
// - shift on tap clock only during shift-dr
// - shift-dr strobe gates the shift register
// - full word moves through pipeline register
// - internal counter sweeps write address range
// - start opcode match enables counters and writes
// - instruction value governs counters and selects
// - ring counter advances after each sweep
// - broadcast select writes all blocks together
// - update rise presents new data and address
// - write clock is inverted update strobe
// - falling-edge RAMs take update strobe directly
// - write clock times data, address, selects
`timescale 1ns/1ps
`default_nettype none

module rit_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);
   // count is one bit wider than the pointers: full and empty differ

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wr_ptr;
      logic [PTR_W-1:0]            rd_ptr;
      logic [PTR_W:0]              count;
   } rit_fifo_st_t;

   rit_fifo_st_t q_ff;
   rit_fifo_st_t nxt_q;
   logic         push;
   logic         pop;

   assign in_ready  = (q_ff.count != (PTR_W+1)'(DEPTH));
   assign out_valid = (q_ff.count != '0);
   assign out_data  = q_ff.mem[q_ff.rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      nxt_q = q_ff;
      if (push) begin
         nxt_q.mem[q_ff.wr_ptr] = in_data;
         nxt_q.wr_ptr = (q_ff.wr_ptr == (PTR_W)'(DEPTH - 1)) ? '0
                        : q_ff.wr_ptr + 1'b1;
      end
      if (pop) begin
         nxt_q.rd_ptr = (q_ff.rd_ptr == (PTR_W)'(DEPTH - 1)) ? '0
                        : q_ff.rd_ptr + 1'b1;
      end
      nxt_q.count = q_ff.count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // checks on the stored stream
   a_fifo_bound:
   assert property (@(posedge clk) disable iff (!reset_n)
      q_ff.count <= (PTR_W+1)'(DEPTH))
      else $error("fifo holds more words than its depth");

   a_fifo_inc:
   assert property (@(posedge clk) disable iff (!reset_n)
      push && !pop |=> q_ff.count == $past(q_ff.count) + 1'b1)
      else $error("fifo count did not rise on push");

   a_fifo_dec:
   assert property (@(posedge clk) disable iff (!reset_n)
      pop && !push |=> q_ff.count == $past(q_ff.count) - 1'b1)
      else $error("fifo count did not fall on pop");

   a_head_hold:
   assert property (@(posedge clk) disable iff (!reset_n)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("fifo head moved before it was taken");
endmodule

module rit_loader #(
   // 0 when the RAMs write on the falling edge of their clock
   parameter bit WCLK_INVERT = 1'b1
) (
   // system side
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          block_broadcast,
   // tap bridge side
   input  wire logic                          tap_dr_clock,
   input  wire logic                          tap_reset_n,
   input  wire logic [rit_pkg::IR_W-1:0]      tap_instruction_value,
   input  wire logic                          tap_shift_dr_strobe,
   input  wire logic                          tap_update_dr_strobe,
   input  wire logic                          tap_serial_data_out,
   output logic                               tap_serial_return,
   // RAM write port
   output logic                               ram_write_clock,
   output logic      [rit_pkg::NUM_BLK-1:0]   ram_chip_sel,
   output logic      [rit_pkg::ADDR_W-1:0]    ram_write_addr,
   output logic      [rit_pkg::DATA_W-1:0]    ram_write_data,
   // loaded-word stream on the system clock
   output logic                               load_valid,
   input  wire logic                          load_ready,
   output rit_pkg::rit_word_t                 load_word,
   output logic                               load_overrun
);
   import rit_pkg::*;

   // index of the one-hot ring bit, reported with each word
   function automatic logic [BLK_W-1:0] onehot_index(
      input logic [NUM_BLK-1:0] oh
   );
      logic [BLK_W-1:0] idx;
      idx = '0;
      for (int i = 0; i < NUM_BLK; i++) begin
         if (oh[i]) begin
            idx = BLK_W'(i);
         end
      end
      return idx;
   endfunction

   rit_tap_st_t t_ff;
   rit_tap_st_t nxt_t;
   rit_sys_st_t s_ff;
   rit_sys_st_t nxt_s;
   logic        ir_match;
   logic        upd_rise;
   logic        push_valid;
   logic        fifo_in_ready;

   // ---------------- tap clock side ----------------
   // ir, strobes and serial data all come from the tap on this clock
   // a mismatched update is refused whole: no data, address or ring move
   assign ir_match = (tap_instruction_value == START_OPCODE);

   always_comb begin
      nxt_t = t_ff;
      upd_rise = tap_update_dr_strobe & ~t_ff.upd_prev;
      nxt_t.upd_prev = tap_update_dr_strobe;
      // ack comes back over two flops before the next word may go
      nxt_t.ack_s1 = s_ff.ack;
      nxt_t.ack_s2 = t_ff.ack_s1;
      // broadcast is a system-side level, resynced like a pin
      nxt_t.bc_s1 = block_broadcast;
      nxt_t.bc_s2 = t_ff.bc_s1;
      if (tap_shift_dr_strobe) begin
         // first bit ends in the msb
         nxt_t.shift = {t_ff.shift[DATA_W-2:0], tap_serial_data_out};
      end
      if (upd_rise && ir_match) begin
         nxt_t.wdata = t_ff.shift;
         nxt_t.addr = t_ff.addr + 1'b1;
         nxt_t.started = 1'b1;
         if (t_ff.started && t_ff.addr == ADDR_LAST) begin
            nxt_t.ring = {t_ff.ring[NUM_BLK-2:0],
                          t_ff.ring[NUM_BLK-1]};
         end
         // a word that finds the crossing busy is lost and flagged
         if (t_ff.req == t_ff.ack_s2) begin
            nxt_t.xfer.blk = onehot_index(nxt_t.ring);
            nxt_t.xfer.addr = nxt_t.addr;
            nxt_t.xfer.data = t_ff.shift;
            nxt_t.req = ~t_ff.req;
         end else begin
            nxt_t.overrun = 1'b1;
         end
      end
   end

   // tap reset restarts the sweep; the system-side fifo keeps its words
   always_ff @(posedge tap_dr_clock or negedge tap_reset_n) begin
      if (!tap_reset_n) begin
         t_ff <= '{shift: DATA_INIT, wdata: DATA_INIT,
                   addr: ADDR_INIT, ring: RING_INIT,
                   default: '0};
      end else begin
         t_ff <= nxt_t;
      end
   end

   assign tap_serial_return = t_ff.shift[DATA_W-1];
   assign ram_write_data    = t_ff.wdata;
   assign ram_write_addr    = t_ff.addr;
   // update stays high a full tap cycle, so data settles first
   assign ram_write_clock   = WCLK_INVERT ? ~tap_update_dr_strobe
                              : tap_update_dr_strobe;
   assign ram_chip_sel      = !ir_match ? '0
                              : (t_ff.bc_s2 ? '1 : t_ff.ring);

   // ---------------- system clock side ----------------
   // xfer is held still until the ack returns, so it is read here whole
   // one word in flight at most, so one toggle bit crosses safely
   assign push_valid = (s_ff.req_s2 != s_ff.ack);

   always_comb begin
      nxt_s = s_ff;
      nxt_s.req_s1 = t_ff.req;
      nxt_s.req_s2 = s_ff.req_s1;
      nxt_s.ovr_s1 = t_ff.overrun;
      nxt_s.ovr_s2 = s_ff.ovr_s1;
      if (push_valid && fifo_in_ready) begin
         nxt_s.ack = s_ff.req_s2;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign load_overrun = s_ff.ovr_s2;

   rit_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (push_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (t_ff.xfer),
      .out_valid (load_valid),
      .out_ready (load_ready),
      .out_data  (load_word)
   );

   // ---------------- checks ----------------
   a_sel_gated:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      !ir_match |-> ram_chip_sel == '0)
      else $error("chip select active without start opcode");

   a_shift_hold:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      !tap_shift_dr_strobe |=> $stable(t_ff.shift))
      else $error("shift register moved outside shift-dr");

   a_shift_bit:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      tap_shift_dr_strobe |=> t_ff.shift ==
         {$past(t_ff.shift[DATA_W-2:0]), $past(tap_serial_data_out)})
      else $error("shift register did not take serial bit");

   a_data_load:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      upd_rise && ir_match |=> ram_write_data == $past(t_ff.shift))
      else $error("write data not loaded on update");

   a_addr_step:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      upd_rise && ir_match |=>
         ram_write_addr == $past(ram_write_addr) + 2'h1)
      else $error("address did not step by one");

   a_ring_step:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      upd_rise && ir_match && t_ff.started && t_ff.addr == ADDR_LAST
      |=> t_ff.ring == {$past(t_ff.ring[NUM_BLK-2:0]),
                        $past(t_ff.ring[NUM_BLK-1])})
      else $error("ring did not rotate after sweep");

   a_idle_hold:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      !ir_match |=> $stable(t_ff.addr) && $stable(t_ff.ring)
         && $stable(t_ff.wdata))
      else $error("counters moved without start opcode");

   a_wclk_stable:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      WCLK_INVERT && $rose(ram_write_clock) |->
         $stable(ram_write_data) && $stable(ram_write_addr))
      else $error("write data changed at write clock edge");

   a_ring_onehot:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      $onehot(t_ff.ring))
      else $error("block ring lost its single select");

   a_bcast_all:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      ir_match && t_ff.bc_s2 |-> ram_chip_sel == '1)
      else $error("broadcast did not select every block");

   a_sel_follow:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      ir_match && !t_ff.bc_s2 |-> ram_chip_sel == t_ff.ring)
      else $error("chip select does not follow the ring");

   a_ring_hold:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      !(upd_rise && ir_match && t_ff.addr == ADDR_LAST) |=>
         $stable(t_ff.ring))
      else $error("ring moved before a sweep ended");

   a_data_stand:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      !(upd_rise && ir_match) |=>
         $stable(ram_write_data) && $stable(ram_write_addr))
      else $error("write word changed between update edges");

   // crossing and overrun on the tap clock, ack on the system clock
   a_req_toggle:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      upd_rise && ir_match && t_ff.req == t_ff.ack_s2 |=>
         t_ff.req != $past(t_ff.req))
      else $error("free crossing did not take the word");

   a_xfer_hold:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      t_ff.req != t_ff.ack_s2 |=> $stable(t_ff.xfer))
      else $error("word in flight changed before its ack");

   a_ovr_set:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      upd_rise && ir_match && t_ff.req != t_ff.ack_s2 |=> t_ff.overrun)
      else $error("lost word did not raise overrun");

   a_ovr_sticky:
   assert property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      t_ff.overrun |=> t_ff.overrun)
      else $error("overrun cleared without tap reset");

   a_push_ack:
   assert property (@(posedge clk) disable iff (!reset_n)
      push_valid && fifo_in_ready |=> !push_valid)
      else $error("loaded word not acknowledged");

   // the crossing waits, never drops, while the fifo is full
   a_full_wait:
   assert property (@(posedge clk) disable iff (!reset_n)
      push_valid && !fifo_in_ready |=> push_valid)
      else $error("parked word dropped while fifo full");

   c_broadcast:
   cover property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      upd_rise && ir_match && t_ff.bc_s2);
   c_ring_wrap:
   cover property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      upd_rise && ir_match && t_ff.ring[NUM_BLK-1]
      && t_ff.addr == ADDR_LAST);
   c_overrun:
   cover property (@(posedge clk) disable iff (!reset_n)
      $rose(load_overrun));
   c_fifo_full:
   cover property (@(posedge clk) disable iff (!reset_n)
      push_valid && !fifo_in_ready);
   c_refused:
   cover property (@(posedge tap_dr_clock) disable iff (!tap_reset_n)
      upd_rise && !ir_match);

endmodule

`default_nettype wire

// ### tb/rit_tap_model.sv
`timescale 1ns/1ps
`default_nettype none
module rit_tap_model (
   // bridge outputs
   output logic                     tap_dr_clock,
   output logic                     tap_reset_n,
   output logic [rit_pkg::IR_W-1:0] tap_instruction_value,
   output logic                     tap_shift_dr_strobe,
   output logic                     tap_update_dr_strobe,
   output logic                     tap_serial_data_out,
   // return path
   input  wire logic                tap_serial_return
);
   import rit_pkg::*;
   logic ck  = 1'b0;
   logic run = 1'b0;
   // gate changes while ck is low, so no runt pulses
   always #7.5 ck = ~ck;
   assign tap_dr_clock = ck & run;
   initial begin
      tap_reset_n = 1'b0;
      tap_instruction_value = '0;
      tap_shift_dr_strobe = 1'b0;
      tap_update_dr_strobe = 1'b0;
      tap_serial_data_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge ck);
   endtask
   task automatic tap_rst();
      tick(1);
      run <= 1'b1;
      tap_reset_n <= 1'b0;
      tick(3);
      tap_reset_n <= 1'b1;
      tick(1);
      run <= 1'b0;
   endtask
   task automatic send(input logic [DATA_W-1:0] d, input logic [IR_W-1:0] ir);
      tick(1);
      run <= 1'b1;
      tap_instruction_value <= ir;
      tap_shift_dr_strobe <= 1'b1;
      for (int i = DATA_W - 1; i >= 0; i--) begin
         tap_serial_data_out <= d[i];
         tick(1);
      end
      tap_shift_dr_strobe <= 1'b0;
      // released data line shows the inverse of its last bit
      tap_serial_data_out <= ~d[0];
      tick(1);
      tap_update_dr_strobe <= 1'b1;
      tick(2);
      tap_update_dr_strobe <= 1'b0;
      tick(2);
      run <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rit_pkg::*;
   logic               clk = 1'b0;
   logic               reset_n = 1'b0;
   logic               block_broadcast = 1'b0;
   logic               load_ready = 1'b0;
   logic               tck, trst_n, shf, upd, sdo, sret, wclk, lv, ovr;
   logic               wclk_fall;
   logic [IR_W-1:0]    ir;
   logic [NUM_BLK-1:0] csel;
   logic [ADDR_W-1:0]  waddr;
   logic [DATA_W-1:0]  wdata;
   rit_word_t          lword;
   int                 fails = 0;
   int                 checked = 0;
   initial forever #12.5 clk = ~clk;
   rit_tap_model rit_tap_model_i (.tap_dr_clock(tck), .tap_reset_n(trst_n),
      .tap_instruction_value(ir), .tap_shift_dr_strobe(shf),
      .tap_update_dr_strobe(upd), .tap_serial_data_out(sdo),
      .tap_serial_return(sret));
   rit_loader #(.WCLK_INVERT(1'b1)) rit_loader_i (.clk(clk),
      .reset_n(reset_n), .block_broadcast(block_broadcast),
      .tap_dr_clock(tck), .tap_reset_n(trst_n), .tap_instruction_value(ir),
      .tap_shift_dr_strobe(shf), .tap_update_dr_strobe(upd),
      .tap_serial_data_out(sdo), .tap_serial_return(sret),
      .ram_write_clock(wclk), .ram_chip_sel(csel), .ram_write_addr(waddr),
      .ram_write_data(wdata), .load_valid(lv), .load_ready(load_ready),
      .load_word(lword), .load_overrun(ovr));
   // second loader for rams that write on the falling edge
   rit_loader #(.WCLK_INVERT(1'b0)) rit_loader_fall_i (.clk(clk),
      .reset_n(reset_n), .block_broadcast(block_broadcast),
      .tap_dr_clock(tck), .tap_reset_n(trst_n), .tap_instruction_value(ir),
      .tap_shift_dr_strobe(shf), .tap_update_dr_strobe(upd),
      .tap_serial_data_out(sdo), .tap_serial_return(),
      .ram_write_clock(wclk_fall), .ram_chip_sel(), .ram_write_addr(),
      .ram_write_data(), .load_valid(), .load_ready(1'b1),
      .load_word(), .load_overrun());
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // write clock sampled where the strobe is settled
   always @(posedge tck) begin
      check(8'(wclk), 8'(!upd));
      check(8'(wclk_fall), 8'(upd));
   end
   task automatic wait_sys(input bit ov, input logic v);
      int n;
      n = 0;
      while (((ov ? ovr : lv) !== v) && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200) begin
         fails++;
         $display("BAD t=%0t wait ran out", $time);
         results();
      end
   endtask
   task automatic pop(input logic [7:0] exp);
      @(negedge clk);
      wait_sys(1'b0, 1'b1);
      check(lword, exp);
      @(posedge clk);
      load_ready <= 1'b1;
      @(posedge clk);
      load_ready <= 1'b0;
   endtask
   function automatic logic [7:0] word_of(input int k);
      return {2'(k / 4), 2'(k), 4'(k) ^ 4'h9};
   endfunction
   task automatic t_idle();
      check(8'(waddr), 8'(ADDR_INIT));
      check(8'(wdata), 8'(DATA_INIT));
      check(8'(csel), 8'h00);
      check(8'(lv), 8'h00);
      $display("test idle done");
   endtask
   task automatic t_wrong_op();
      rit_tap_model_i.send(4'ha, START_OPCODE + 8'h01);
      check(8'(waddr), 8'(ADDR_INIT));
      check(8'(wdata), 8'(DATA_INIT));
      check(8'(csel), 8'h00);
      repeat (10) @(negedge clk);
      check(8'(lv), 8'h00);
      $display("test wrong opcode done");
   endtask
   // fifo stalls: 32 held, one parked in the crossing, one lost
   task automatic t_fill();
      logic [7:0] w;
      for (int k = 0; k < FIFO_DEPTH + 2; k++) begin
         w = word_of(k);
         rit_tap_model_i.send(w[3:0], START_OPCODE);
         check(8'(wdata), 8'(w[3:0]));
         check(8'(waddr), 8'(w[5:4]));
         check(8'(csel), 8'(4'h1 << w[7:6]));
         check(8'(sret), 8'(w[3]));
      end
      wait_sys(1'b1, 1'b1);
      check(8'(ovr), 8'h01);
      for (int k = 0; k <= FIFO_DEPTH; k++) pop(word_of(k));
      @(negedge clk);
      check(8'(lv), 8'h00);
      check(8'(ovr), 8'h01);
      $display("test fill and drain done");
   endtask
   task automatic t_bcast();
      @(posedge clk);
      block_broadcast <= 1'b1;
      rit_tap_model_i.send(4'h5, START_OPCODE);
      check(8'(csel), 8'h0f);
      pop(8'h25);
      @(posedge clk);
      block_broadcast <= 1'b0;
      $display("test broadcast done");
   endtask
   task automatic t_tap_reset();
      @(posedge clk);
      reset_n <= 1'b0;
      rit_tap_model_i.tap_rst();
      @(posedge clk);
      reset_n <= 1'b1;
      check(8'(waddr), 8'(ADDR_INIT));
      wait_sys(1'b1, 1'b0);
      rit_tap_model_i.send(4'hc, START_OPCODE);
      check(8'(waddr), 8'h00);
      pop(8'h0c);
      $display("test tap reset done");
   endtask
   initial begin
      fork
         rit_tap_model_i.tap_rst();
         repeat (12) @(posedge clk);
      join
      reset_n <= 1'b1;
      @(negedge clk);
      t_idle();
      t_wrong_op();
      t_fill();
      t_bcast();
      t_tap_reset();
      results();
   end
endmodule
`default_nettype wire
